/* File: core_exec_params.svh */
`ifndef CORE_EXEC_PARAMS_SVH
`define CORE_EXEC_PARAMS_SVH
// Notes on behaviour
// - Skip taken costs two cycles, else one.
// - Writing pc low byte costs two cycles.
// - Preclear pair back to back clears flags.
// - Halt enters power-down, clears timeout flag, sets powerdown flag.
// - Skip on zero byte; move variant loads accumulator.
// - Bit test skips on clear or set.
// - Increment/decrement, skip on zero result.
// - Returns take two cycles, value loads accumulator.
// - Table read: high part, low byte, two cycles.
// - Nibble swap to memory or accumulator.
// - Add with carry into accumulator, four flags.
// - Add with carry into memory, four flags.
// - Add memory into accumulator, four flags.
// - Add literal into accumulator, four flags.
// - Add accumulator into memory, four flags.
// - AND memory or literal into accumulator, zero.
// - AND into memory, zero flag only.
// - Watchdog clear resets counter and both flags.
// - Call pushes pc plus one, two cycles.

// Register byte offsets, low address byte decoded.
`define OFS_INSTR 8'h00
`define OFS_STATUS 8'h04
`define OFS_PC 8'h08
`define OFS_DM_PTR 8'h0C
`define OFS_DM_DATA 8'h10
`define OFS_PM_PTR 8'h14
`define OFS_PM_DATA 8'h18
`define OFS_TABLE 8'h1C
`define OFS_CTRL 8'h20
`define OFS_WDT 8'h24

// Instruction word and control register fields.
`define INSTR_OP_LSB 16
`define INSTR_OP_MSB 20
`define CTRL_WAKE_BIT 0

// Data memory address that aliases the pc low byte.
`define PCL_ADDR 7'h06

// Reset values.
`define ACC_RST 8'h00
`define PC_RST 11'h000
`endif

/* File: core_exec_pkg.sv */
package core_exec_pkg;

    typedef enum logic [4:0] {
        nop_op = 5'h00, add_mem_op = 5'h01, sum_mem_op = 5'h02,
        add_imm_op = 5'h03, add_carry_acc_op = 5'h04,
        add_carry_mem_op = 5'h05, and_mem_op = 5'h06, and_imm_op = 5'h07,
        bitwise_conj_mem_op = 5'h08, skip_zero_op = 5'h09,
        skip_zero_move_op = 5'h0A, skip_bit_clear_op = 5'h0B,
        skip_bit_set_op = 5'h0C, inc_skip_op = 5'h0D, dec_skip_op = 5'h0E,
        inc_skip_acc_op = 5'h0F, dec_skip_acc_op = 5'h10, call_op = 5'h11,
        subroutine_return_op = 5'h12, value_return_op = 5'h13,
        interrupt_return_op = 5'h14, table_read_current_op = 5'h15,
        table_read_last_op = 5'h16, watchdog_clear_op = 5'h17,
        watchdog_preclear_a_op = 5'h18, watchdog_preclear_b_op = 5'h19,
        swap_mem_op = 5'h1A, nibble_swap_acc_op = 5'h1B, halt_op = 5'h1C
    } op_e;

    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_exec = 3'b010,
        st_second = 3'b100
    } state_e;

    typedef enum logic [2:0] {
        alu_pass = 3'h0, alu_add = 3'h1, alu_and = 3'h2,
        alu_inc = 3'h3, alu_dec = 3'h4, alu_swap = 3'h5
    } alu_fn_e;

    typedef struct packed {
        logic overflow_flag;
        logic zero_flag;
        logic aux_carry_flag;
        logic carry_flag;
    } alu_flags_s;

    typedef struct packed {
        op_e op;
        logic [10:0] operand;
    } instr_s;

    typedef struct packed {
        logic powerdown;
        logic busy;
        logic timeout_flag;
        logic powerdown_flag;
        alu_flags_s flags;
        logic [7:0] acc;
    } status_s;

endpackage : core_exec_pkg

/* File: exec_alu.sv */
module exec_alu (
    // Operands.
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic cin,
    input wire core_exec_pkg::alu_fn_e fn,
    // Result.
    output logic [7:0] y,
    output core_exec_pkg::alu_flags_s fl
);

    logic [8:0] sum;
    logic [4:0] half;

    // One adder serves every add form; the caller zeroes cin for plain add.
    assign sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    assign half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};

    // Result select.
    always_comb begin
        y = b;
        unique case (fn)
            core_exec_pkg::alu_pass: y = b;
            core_exec_pkg::alu_add: y = sum[7:0];
            core_exec_pkg::alu_and: y = a & b;
            core_exec_pkg::alu_inc: y = a + 8'h01;
            core_exec_pkg::alu_dec: y = a - 8'h01;
            core_exec_pkg::alu_swap: y = {a[3:0], a[7:4]};
            default: y = b;
        endcase
    end

    assign fl.zero_flag = (y == 8'h00);
    assign fl.carry_flag = sum[8];
    assign fl.aux_carry_flag = half[4];
    assign fl.overflow_flag = (a[7] == b[7]) && (sum[7] != a[7]);

endmodule : exec_alu

/* File: core_exec.sv */
// Local design decisions: the AHB-Lite slave port and the address map.
`include "core_exec_params.svh"

module core_exec #(
    parameter int DM_WORDS = 88,
    parameter int PM_WORDS = 2048,
    parameter int STACK_DEPTH = 6,
    parameter int WDT_BITS = 16
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // AHB-Lite slave port.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Core state.
    output logic busy,
    output logic powerdown
);

    localparam int SPW = $clog2(STACK_DEPTH);

    ////////////////////////////////////////////////////////////////////////
    // Storage and state.

    logic [7:0] dmem [DM_WORDS];
    logic [13:0] pmem [PM_WORDS];
    logic [10:0] stack [STACK_DEPTH];
    logic [SPW-1:0] sp;
    core_exec_pkg::state_e state;
    core_exec_pkg::state_e next_state;
    core_exec_pkg::instr_s ins;
    core_exec_pkg::alu_flags_s flags;
    logic [7:0] accumulator_reg;
    logic [10:0] pc;
    logic [7:0] table_ptr;
    logic [5:0] table_high_reg;
    logic timeout_flag;
    logic powerdown_flag;
    logic [WDT_BITS-1:0] watchdog_counter;
    logic last_pre_a;
    logic last_pre_b;
    logic [6:0] dm_ptr;
    logic [10:0] pm_ptr;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave.

    logic addr_phase;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] bus_addr;
    logic [31:0] rd_mux;

    // A transfer is taken when selected, non-idle and the bus is ready.
    assign addr_phase = hsel && htrans[1] && hready;

    // Reads insert one wait state so that data reflects a write just done.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            bus_addr <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
        end else begin
            wr_pend <= addr_phase && hwrite;
            rd_pend <= addr_phase && !hwrite;
            hreadyout <= !(addr_phase && !hwrite);
            hresp <= 1'b0;
            if (addr_phase) begin
                bus_addr <= haddr[7:0];
            end
            if (rd_pend) begin
                hrdata <= rd_mux;
            end
        end
    end

    logic idle;
    logic w_instr;
    logic w_pc;
    logic w_dm_ptr;
    logic w_dm_data;
    logic w_pm_ptr;
    logic w_pm_data;
    logic w_table;
    logic wake;
    logic launch;

    // Write decode; pc and data memory writes are refused while an instruction runs.
    assign idle = (state == core_exec_pkg::st_idle);
    assign w_instr = wr_pend && (bus_addr == `OFS_INSTR);
    assign w_pc = wr_pend && idle && (bus_addr == `OFS_PC);
    assign w_dm_ptr = wr_pend && (bus_addr == `OFS_DM_PTR);
    assign w_dm_data = wr_pend && idle && (bus_addr == `OFS_DM_DATA);
    assign w_pm_ptr = wr_pend && (bus_addr == `OFS_PM_PTR);
    assign w_pm_data = wr_pend && (bus_addr == `OFS_PM_DATA);
    assign w_table = wr_pend && (bus_addr == `OFS_TABLE);
    assign wake = wr_pend && (bus_addr == `OFS_CTRL)
        && hwdata[`CTRL_WAKE_BIT];
    assign launch = w_instr && idle && !powerdown;

    core_exec_pkg::status_s status_word;
    logic [7:0] dm_rd;
    logic [13:0] pm_rd;

    // Read selection; unmapped offsets read as zero.
    assign status_word = {powerdown, busy, timeout_flag, powerdown_flag,
        flags, accumulator_reg};
    assign dm_rd = (32'(dm_ptr) < DM_WORDS) ? dmem[dm_ptr] : 8'h00;
    assign pm_rd = (32'(pm_ptr) < PM_WORDS) ? pmem[pm_ptr] : 14'h0000;
    assign rd_mux =
        (bus_addr == `OFS_INSTR) ? {11'h000, ins.op, 5'h00, ins.operand} :
        (bus_addr == `OFS_STATUS) ? {16'h0000, status_word} :
        (bus_addr == `OFS_PC) ? {21'h00_0000, pc} :
        (bus_addr == `OFS_DM_PTR) ? {25'h000_0000, dm_ptr} :
        (bus_addr == `OFS_DM_DATA) ? {24'h00_0000, dm_rd} :
        (bus_addr == `OFS_PM_PTR) ? {21'h00_0000, pm_ptr} :
        (bus_addr == `OFS_PM_DATA) ? {18'h0_0000, pm_rd} :
        (bus_addr == `OFS_TABLE) ?
            {18'h0_0000, table_high_reg, table_ptr} :
        (bus_addr == `OFS_WDT) ?
            32'(watchdog_counter) : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Operand fetch and decode.

    logic [6:0] m_addr;
    logic [2:0] bit_sel;
    logic [7:0] imm;
    logic [7:0] m_val;
    logic pcl_hit;

    // The pc low byte shadows one data memory address.
    assign m_addr = ins.operand[6:0];
    assign bit_sel = ins.operand[10:8];
    assign imm = ins.operand[7:0];
    assign pcl_hit = (m_addr == `PCL_ADDR);
    assign m_val = pcl_hit ? pc[7:0] :
        (32'(m_addr) < DM_WORDS) ? dmem[m_addr] : 8'h00;

    core_exec_pkg::alu_fn_e fn;
    logic use_imm;
    logic use_carry;
    logic to_acc;
    logic to_mem;
    logic upd_arith;
    logic upd_z;
    logic skip_test;
    logic skip_on_zero;
    logic fixed_two;
    logic do_push;
    logic do_pop;
    logic do_table;
    logic last_page;
    logic wd_clear;
    logic pre_a;
    logic pre_b;
    logic do_halt;

    // Per-opcode control; unused codes act as no operation.
    always_comb begin
        fn = core_exec_pkg::alu_pass;
        use_imm = 1'b0;
        use_carry = 1'b0;
        to_acc = 1'b0;
        to_mem = 1'b0;
        upd_arith = 1'b0;
        upd_z = 1'b0;
        skip_test = 1'b0;
        skip_on_zero = 1'b0;
        fixed_two = 1'b0;
        do_push = 1'b0;
        do_pop = 1'b0;
        do_table = 1'b0;
        last_page = 1'b0;
        wd_clear = 1'b0;
        pre_a = 1'b0;
        pre_b = 1'b0;
        do_halt = 1'b0;
        unique case (ins.op)
            core_exec_pkg::add_carry_acc_op: begin
                fn = core_exec_pkg::alu_add;
                use_carry = 1'b1;
                to_acc = 1'b1;
                upd_arith = 1'b1;
            end
            core_exec_pkg::add_carry_mem_op: begin
                fn = core_exec_pkg::alu_add;
                use_carry = 1'b1;
                to_mem = 1'b1;
                upd_arith = 1'b1;
            end
            core_exec_pkg::add_mem_op: begin
                fn = core_exec_pkg::alu_add;
                to_acc = 1'b1;
                upd_arith = 1'b1;
            end
            core_exec_pkg::add_imm_op: begin
                fn = core_exec_pkg::alu_add;
                use_imm = 1'b1;
                to_acc = 1'b1;
                upd_arith = 1'b1;
            end
            core_exec_pkg::sum_mem_op: begin
                fn = core_exec_pkg::alu_add;
                to_mem = 1'b1;
                upd_arith = 1'b1;
            end
            core_exec_pkg::and_mem_op, core_exec_pkg::and_imm_op: begin
                fn = core_exec_pkg::alu_and;
                use_imm = (ins.op == core_exec_pkg::and_imm_op);
                to_acc = 1'b1;
                upd_z = 1'b1;
            end
            core_exec_pkg::bitwise_conj_mem_op: begin
                fn = core_exec_pkg::alu_and;
                to_mem = 1'b1;
                upd_z = 1'b1;
            end
            core_exec_pkg::skip_zero_op: skip_test = (m_val == 8'h00);
            core_exec_pkg::skip_zero_move_op: begin
                skip_test = (m_val == 8'h00);
                to_acc = 1'b1;
            end
            core_exec_pkg::skip_bit_clear_op: skip_test = !m_val[bit_sel];
            core_exec_pkg::skip_bit_set_op: skip_test = m_val[bit_sel];
            core_exec_pkg::inc_skip_op, core_exec_pkg::inc_skip_acc_op:
            begin
                fn = core_exec_pkg::alu_inc;
                skip_on_zero = 1'b1;
                to_mem = (ins.op == core_exec_pkg::inc_skip_op);
                to_acc = (ins.op == core_exec_pkg::inc_skip_acc_op);
            end
            core_exec_pkg::dec_skip_op, core_exec_pkg::dec_skip_acc_op:
            begin
                fn = core_exec_pkg::alu_dec;
                skip_on_zero = 1'b1;
                to_mem = (ins.op == core_exec_pkg::dec_skip_op);
                to_acc = (ins.op == core_exec_pkg::dec_skip_acc_op);
            end
            core_exec_pkg::call_op: begin
                do_push = 1'b1;
                fixed_two = 1'b1;
            end
            core_exec_pkg::subroutine_return_op,
            core_exec_pkg::interrupt_return_op: begin
                do_pop = 1'b1;
                fixed_two = 1'b1;
            end
            core_exec_pkg::value_return_op: begin
                do_pop = 1'b1;
                fixed_two = 1'b1;
                use_imm = 1'b1;
                to_acc = 1'b1;
            end
            core_exec_pkg::table_read_current_op,
            core_exec_pkg::table_read_last_op: begin
                do_table = 1'b1;
                last_page = (ins.op == core_exec_pkg::table_read_last_op);
                to_mem = 1'b1;
                fixed_two = 1'b1;
            end
            core_exec_pkg::watchdog_clear_op: wd_clear = 1'b1;
            core_exec_pkg::watchdog_preclear_a_op: pre_a = 1'b1;
            core_exec_pkg::watchdog_preclear_b_op: pre_b = 1'b1;
            core_exec_pkg::swap_mem_op: begin
                fn = core_exec_pkg::alu_swap;
                to_mem = 1'b1;
            end
            core_exec_pkg::nibble_swap_acc_op: begin
                fn = core_exec_pkg::alu_swap;
                to_acc = 1'b1;
            end
            core_exec_pkg::halt_op: do_halt = 1'b1;
            default: fn = core_exec_pkg::alu_pass;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Datapath.

    logic [7:0] alu_a;
    logic [7:0] alu_b;
    logic [7:0] alu_y;
    core_exec_pkg::alu_flags_s alu_fl;
    logic [10:0] pm_addr;
    logic [13:0] pm_word;
    logic [7:0] mem_wdata;
    logic skip_now;
    logic pcl_write;
    logic two_now;
    logic exec;
    logic [SPW-1:0] sp_up;
    logic [SPW-1:0] sp_down;
    logic [10:0] next_pc;

    // Step and swap work on the memory byte, the rest on the accumulator.
    assign alu_a = (fn == core_exec_pkg::alu_inc
        || fn == core_exec_pkg::alu_dec
        || fn == core_exec_pkg::alu_swap) ? m_val : accumulator_reg;
    assign alu_b = use_imm ? imm : m_val;

    exec_alu u_alu (
        .a(alu_a),
        .b(alu_b),
        .cin(use_carry & flags.carry_flag),
        .fn(fn),
        .y(alu_y),
        .fl(alu_fl)
    );

    // Table word comes from the pc page or the last page.
    assign pm_addr = {last_page ? 3'h7 : pc[10:8], table_ptr};
    assign pm_word = (32'(pm_addr) < PM_WORDS) ? pmem[pm_addr] : 14'h0000;
    assign mem_wdata = do_table ? pm_word[7:0] : alu_y;

    assign skip_now = skip_test || (skip_on_zero && alu_fl.zero_flag);
    assign pcl_write = to_mem && pcl_hit;
    assign two_now = fixed_two || skip_now || pcl_write;
    assign exec = (state == core_exec_pkg::st_exec);

    // Stack pointer wraps after the last level, overwriting the oldest.
    assign sp_up = (32'(sp) == STACK_DEPTH - 1) ? '0 : sp + 1'b1;
    assign sp_down = (sp == '0) ? SPW'(STACK_DEPTH - 1) : sp - 1'b1;
    assign next_pc = do_push ? ins.operand :
        do_pop ? stack[sp_down] :
        pcl_write ? {pc[10:8], mem_wdata} :
        skip_now ? pc + 11'h002 : pc + 11'h001;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer.

    // Idle, one execute cycle, and a second cycle where needed.
    always_comb begin
        next_state = state;
        unique case (state)
            core_exec_pkg::st_idle:
                next_state = launch ? core_exec_pkg::st_exec : state;
            core_exec_pkg::st_exec:
                next_state = two_now ? core_exec_pkg::st_second
                    : core_exec_pkg::st_idle;
            core_exec_pkg::st_second: next_state = core_exec_pkg::st_idle;
        endcase
    end

    // State, busy and the latched instruction.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= core_exec_pkg::st_idle;
            busy <= 1'b0;
            ins <= '0;
        end else begin
            state <= next_state;
            busy <= (next_state != core_exec_pkg::st_idle);
            if (launch) begin
                // Opcode and operand sit apart in the bus word.
                ins <= core_exec_pkg::instr_s'({
                    hwdata[`INSTR_OP_MSB:`INSTR_OP_LSB], hwdata[10:0]});
            end
        end
    end

    // Accumulator and arithmetic flags.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            accumulator_reg <= `ACC_RST;
            flags <= '0;
        end else if (exec) begin
            if (to_acc) accumulator_reg <= alu_y;
            if (upd_arith) flags <= alu_fl;
            if (upd_z) flags.zero_flag <= alu_fl.zero_flag;
        end
    end

    // Program counter and return stack.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pc <= `PC_RST;
            sp <= '0;
        end else if (exec) begin
            pc <= next_pc;
            if (do_push) begin
                stack[sp] <= pc + 11'h001;
                sp <= sp_up;
            end else if (do_pop) begin
                sp <= sp_down;
            end
        end else if (w_pc) begin
            pc <= hwdata[10:0];
        end
    end

    // Data memory; the execute write has the port while busy.
    always_ff @(posedge clk) begin
        if (exec && to_mem && !pcl_hit && 32'(m_addr) < DM_WORDS) begin
            dmem[m_addr] <= mem_wdata;
        end else if (w_dm_data && 32'(dm_ptr) < DM_WORDS) begin
            dmem[dm_ptr] <= hwdata[7:0];
        end
        if (w_pm_data && 32'(pm_ptr) < PM_WORDS) begin
            pmem[pm_ptr] <= hwdata[13:0];
        end
    end

    // Pointers and the table high part.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dm_ptr <= 7'h00;
            pm_ptr <= 11'h000;
            table_ptr <= 8'h00;
            table_high_reg <= 6'h00;
        end else begin
            if (w_dm_ptr) dm_ptr <= hwdata[6:0];
            if (w_pm_ptr) pm_ptr <= hwdata[10:0];
            if (w_table) table_ptr <= hwdata[7:0];
            if (exec && do_table) table_high_reg <= pm_word[13:8];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Watchdog, power-down and their flags.

    logic pair_done;
    logic wd_reset;
    logic wd_overflow;

    assign pair_done = exec && ((pre_a && last_pre_b) || (pre_b && last_pre_a));
    assign wd_reset = pair_done || (exec && wd_clear);
    assign wd_overflow = &watchdog_counter;

    // Any other instruction between the two halves breaks the pair.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            last_pre_a <= 1'b0;
            last_pre_b <= 1'b0;
        end else if (exec) begin
            last_pre_a <= pre_a && !pair_done;
            last_pre_b <= pre_b && !pair_done;
        end
    end

    // A counter overflow sets the timeout flag except in a clearing cycle.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            watchdog_counter <= '0;
            timeout_flag <= 1'b0;
            powerdown_flag <= 1'b0;
            powerdown <= 1'b0;
        end else begin
            watchdog_counter <= wd_reset ? '0 : watchdog_counter + 1'b1;
            if (wd_reset) begin
                timeout_flag <= 1'b0;
                powerdown_flag <= 1'b0;
            end
            if (exec && do_halt) begin
                timeout_flag <= 1'b0;
                powerdown_flag <= 1'b1;
                powerdown <= 1'b1;
            end else if (wake || wd_overflow) begin
                powerdown <= 1'b0;
            end
            if (wd_overflow && !wd_reset) begin
                timeout_flag <= 1'b1;
            end
        end
    end

endmodule : core_exec

/* File: core_exec_sva.sv */
module core_exec_sva (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Bus request.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    // Core state.
    input wire logic busy,
    input wire logic powerdown
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic wr_q;
    wire logic [4:0] op;
    wire logic go;
    // An instruction write that the core will take in this data phase.
    assign op = hwdata[20:16];
    assign go = wr_q && !busy && !powerdown;
    // Remembers the instruction address phase for one cycle.
    always_ff @(posedge clk) begin
        wr_q <= rst_n && hsel && htrans[1] && hready && hwrite
            && haddr[7:0] == 8'h00;
    end
    ////////////////////////////////////////
    property p_cap; busy ##1 busy |=> !busy; endproperty
    a_cap: assert property (p_cap) else $error("busy too long");
    property p_add; go && op == 5'h01 |=> busy ##1 !busy; endproperty
    a_add: assert property (p_add) else $error("add time");
    property p_swp; go && op == 5'h1B |=> busy ##1 !busy; endproperty
    a_swp: assert property (p_swp) else $error("swap time");
    property p_clr; go && op == 5'h17 |=> busy ##1 !busy; endproperty
    a_clr: assert property (p_clr) else $error("clear time");
    property p_hlt; go && op == 5'h1C |=> busy ##1 !busy ##[0:2] powerdown;
    endproperty
    a_hlt: assert property (p_hlt) else $error("halt");
    property p_cal; go && op == 5'h11 |=> busy[*2] ##1 !busy; endproperty
    a_cal: assert property (p_cal) else $error("call time");
    property p_ret; go && op inside {5'h12, 5'h13, 5'h14}
        |=> busy[*2] ##1 !busy; endproperty
    a_ret: assert property (p_ret) else $error("return time");
    property p_tab; go && op inside {5'h15, 5'h16} |=> busy[*2] ##1 !busy;
    endproperty
    a_tab: assert property (p_tab) else $error("table time");
    c_hlt: cover property (go && op == 5'h1C);
    c_two: cover property (busy ##1 busy);
    c_cal: cover property (go && op == 5'h11);
endmodule : core_exec_sva
bind core_exec core_exec_sva u_sva (.clk, .rst_n, .hsel, .haddr, .htrans,
    .hwrite, .hwdata, .hready, .busy, .powerdown);

/* File: ahb_host.sv */
module ahb_host (
    // Bus clock.
    input wire logic clk,
    // Request.
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    // Answer.
    input wire logic [31:0] hrdata,
    input wire logic hreadyout
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus from time zero; only whole words move.
    initial begin
        {hsel, haddr, htrans, hwrite, hwdata} <= '0;
        hsize <= 3'h2;
    end
    // Each phase is held until a rising edge samples ready high.
    task automatic xfer(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : xfer
endmodule : ahb_host

/* File: core_exec_tb.sv */
module core_exec_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, busy, powerdown;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int errors = 0;
    int n_compared = 0;
    int n;
    // System clock, 20 ns period.
    always #10 clk = ~clk;
    // Full watchdog width: the run ends long before it overflows.
    core_exec #(.WDT_BITS(16)) dut (.clk, .rst_n, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp, .busy, .powerdown);
    ahb_host host (.clk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hrdata, .hreadyout);
    ////////////////////////////////////////
    // Compare and count.
    task automatic chk(input string s, input logic [31:0] e,
            input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s exp %h got %h", s, e, g);
        end
    endtask : chk
    // Register access; read data lands in q.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        host.xfer(1'b0, a, 32'h0, q);
    endtask : rd
    // Issue one instruction and count its busy cycles into n.
    task automatic ex(input logic [4:0] op, input logic [10:0] arg);
        wr(8'h00, {11'h0, op, 5'h0, arg});
        n = 0;
        @(negedge clk);
        while (busy === 1'b1) begin
            n++;
            @(negedge clk);
        end
        @(posedge clk);
    endtask : ex
    // Arithmetic, swap and logic results with their flags.
    task automatic t_alu;
        ex(5'h03, 11'h07F);
        ex(5'h03, 11'h001);
        rd(8'h04);
        chk("add imm", 32'h0000_0A80, q & 32'h0000_0FFF);
        ex(5'h03, 11'h080);
        rd(8'h04);
        chk("carry", 32'h0000_0D00, q & 32'h0000_0FFF);
        wr(8'h0C, 32'h0000_0010);
        wr(8'h10, 32'h0000_0005);
        ex(5'h05, 11'h010);
        rd(8'h10);
        chk("adc mem", 32'h0000_0006, q);
        ex(5'h1B, 11'h010);
        rd(8'h04);
        chk("swap acc", 32'h0000_0060, q & 32'h0000_0FFF);
        ex(5'h08, 11'h010);
        rd(8'h04);
        chk("and flags", 32'h0000_0460, q & 32'h0000_0FFF);
        rd(8'h10);
        chk("and mem", 32'h0000_0000, q);
        ex(5'h01, 11'h010);
        rd(8'h04);
        chk("add mem", 32'h0000_0060, q & 32'h0000_0FFF);
        chk("hresp", 32'h0000_0000, hresp);
    endtask : t_alu
    // Skips, call, return and table read: timing and program counter.
    task automatic t_flow;
        wr(8'h08, 32'h0000_0010);
        ex(5'h09, 11'h010);
        chk("skip time", 32'h0000_0002, n);
        wr(8'h0C, 32'h0000_0011);
        wr(8'h10, 32'h0000_0000);
        ex(5'h0E, 11'h011);
        chk("noskip time", 32'h0000_0001, n);
        rd(8'h10);
        chk("dec mem", 32'h0000_00FF, q);
        ex(5'h11, 11'h123);
        chk("call time", 32'h0000_0002, n);
        ex(5'h12, 11'h000);
        chk("ret time", 32'h0000_0002, n);
        rd(8'h08);
        chk("ret pc", 32'h0000_0014, q);
        ex(5'h15, 11'h011);
        chk("table time", 32'h0000_0002, n);
    endtask : t_flow
    // Halt, wake and the two ways of clearing the flags.
    task automatic t_wdt;
        ex(5'h1C, 11'h000);
        rd(8'h04);
        chk("halt flags", 32'h0000_9000, q & 32'h0000_B000);
        wr(8'h20, 32'h0000_0001);
        ex(5'h18, 11'h000);
        ex(5'h18, 11'h000);
        rd(8'h04);
        chk("half clear", 32'h0000_1000, q & 32'h0000_3000);
        ex(5'h19, 11'h000);
        rd(8'h04);
        chk("pair clear", 32'h0000_0000, q & 32'h0000_3000);
        ex(5'h1C, 11'h000);
        wr(8'h20, 32'h0000_0001);
        ex(5'h17, 11'h000);
        rd(8'h04);
        chk("wdt clear", 32'h0000_0000, q & 32'h0000_3000);
    endtask : t_wdt
    // Counts and verdict.
    task automatic end_sim;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim
    // Main sequence after six reset cycles.
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_alu();
        t_flow();
        t_wdt();
        end_sim();
    end
    // A hang costs a few thousand cycles at most before it is cut.
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        end_sim();
    end
endmodule : core_exec_tb
